// File: scm_map.svh
`ifndef SCM_MAP_SVH
`define SCM_MAP_SVH

// Register addresses
`define SCM_ADDR_MODE 20'hFFFB0
`define SCM_ADDR_BAUD 20'hFFFB1
`define SCM_ADDR_CTRL 20'hFFFB2
`define SCM_ADDR_TXD 20'hFFFB3
`define SCM_ADDR_STAT 20'hFFFB4
`define SCM_ADDR_RXD 20'hFFFB5
`define SCM_ADDR_CARD 20'hFFFB6

// Reset values
`define SCM_RST_MODE 8'h00
`define SCM_RST_BAUD 8'hFF
`define SCM_RST_CTRL 8'h00
`define SCM_RST_TXD 8'hFF
`define SCM_RST_RXD 8'h00
`define SCM_RST_CARD 8'hF2
`define SCM_CARD_ONES 8'hF2
`define SCM_RST_ORDER 1'b0
`define SCM_RST_INV 1'b0
`define SCM_RST_ON 1'b0

// Mode register fields
`define SCM_MODE_GSM 7
`define SCM_MODE_ODD 4
`define SCM_MODE_PRE_HI 1
`define SCM_MODE_PRE_LO 0

// Control register fields
`define SCM_CTRL_TXON 5
`define SCM_CTRL_RXON 4
`define SCM_CTRL_CK_HI 1
`define SCM_CTRL_CK_LO 0

// Status register fields
`define SCM_STAT_TXE 7
`define SCM_STAT_RXF 6
`define SCM_STAT_OVR 5
`define SCM_STAT_ERS 4
`define SCM_STAT_PAR 3
`define SCM_STAT_TX_DONE_FLAG 2

// Card mode register fields
`define SCM_CARD_ORDER 3
`define SCM_CARD_INV 2
`define SCM_CARD_ON 0

// Card clock ratio per bit, and base ticks per half etu
`define SCM_CLK_PER_ETU 372
`define SCM_TICKS_HALF (`SCM_CLK_PER_ETU)

// Frame timing in tenths of an etu, points counted from the start edge and lengths
`define SCM_TX_DONE_FLAG_NORM_X10 125
`define SCM_TX_DONE_FLAG_GSM_X10 110
`define SCM_ERR_OUT_X10 105
`define SCM_ERR_LEN_X10 10
`define SCM_ERR_SMP_X10 110
`define SCM_FRAME_X10 100
`define SCM_GUARD_X10 20
`define SCM_RETRY_X10 20

// Same timing in half etu
`define SCM_TX_DONE_FLAG_NORM_H (`SCM_TX_DONE_FLAG_NORM_X10 / 5)
`define SCM_TX_DONE_FLAG_GSM_H (`SCM_TX_DONE_FLAG_GSM_X10 / 5)
`define SCM_ERR_ON_H (`SCM_ERR_OUT_X10 / 5)
`define SCM_ERR_OFF_H ((`SCM_ERR_OUT_X10 + `SCM_ERR_LEN_X10) / 5)
`define SCM_ERR_SMP_H (`SCM_ERR_SMP_X10 / 5)
`define SCM_FRAME_H (`SCM_FRAME_X10 / 5)
`define SCM_GUARD_END_H ((`SCM_FRAME_X10 + `SCM_GUARD_X10) / 5)
`define SCM_RETRY_H ((`SCM_ERR_SMP_X10 + `SCM_RETRY_X10) / 5)
`define SCM_PAR_SMP_H 18
`define SCM_RX_END_H 24

`endif

// File: scm_pkg.sv
package scm_pkg;
  typedef logic [19:0] scm_addr_t;
  typedef logic [7:0] scm_byte_t;
  typedef enum logic {SCM_TX_IDLE, SCM_TX_FRAME} scm_tx_state_t;
  typedef enum logic {SCM_RX_IDLE, SCM_RX_FRAME} scm_rx_state_t;
endpackage

// File: scm_sync.sv
`timescale 1ns/1ps
module scm_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input logic ref_clk,
  input logic rst_n,
  input logic ce,
  input logic async_in,
  output logic sync_out
);
  logic meta_r;

  // Two stages, the first read only by the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (ce) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// File: scm_top.sv
// Operation
// - Normal timing: transmit done flag set 12.5 etu after start edge.
// - Gsm timing: transmit done flag set 11.0 etu after start edge.
// - Gsm off: clock select low picks port or card clock output.
// - Gsm on: clock pin fixed by high select, or card clock.
// - Each frame holds eight data bits then one parity bit.
// - Transmit low start bit, data bits D0 to D7, then parity.
// - At least 2 etu guard between parity end and next start.
// - Parity error received: drive line low one etu from 10.5 etu.
// - Error pulse after transmit: resend same character 2 etu later or more.
// - Only asynchronous character transfer, no synchronous mode.
// - Transmitter releases the data line after the frame.
// - Receiver releases the line once its error pulse ends.
// - Transmit and receive both on allow a loop-back self test.
// - Bit order select picks msb or lsb first both directions.
// - Data invert acts on data bits only, never the parity bit.
// - Error signal flag set when a low error pulse is sampled.
// - Card clock output runs at 372 times the bit rate.
`timescale 1ns/1ps
`include "scm_map.svh"
module scm_top (
  input logic ref_clk,
  input logic rst_n,
  input logic ce,
  input scm_pkg::scm_addr_t addr,
  input scm_pkg::scm_byte_t wr_data,
  input logic wr_stb,
  input logic rd_stb,
  output scm_pkg::scm_byte_t rd_data,
  input logic data_in,
  output logic data_out,
  output logic data_oe,
  output logic sck_out,
  output logic sck_oe
);
  import scm_pkg::*;

  scm_byte_t mode_r, baud_r, ctrl_r, tdr_r, rdr_r;
  logic order_r, inv_r, card_on_r;
  logic txe_r, rxf_r, ovr_r, ers_r, per_r, tx_done_flag_r;
  logic line_s, line_prev_r;
  logic [14:0] tick_cnt_r;
  logic [14:0] tick_lim;
  logic tick;
  logic sck_tgl_r;
  scm_tx_state_t t_state_r;
  scm_rx_state_t r_state_r;
  logic [8:0] t_sub_r, r_sub_r;
  logic [4:0] t_half_r, r_half_r;
  logic [9:0] frame_r;
  logic err_seen_r;
  logic [8:0] rx_bits_r;
  logic [8:0] rx_full;
  logic r_perr_r, r_drv_r;
  logic t_hp, r_hp, tx_en, rx_en, tx_load;
  logic gsm, odd, ck_hi, ck_lo;
  scm_byte_t d_tx, rx_byte;
  logic rx_done, rx_perr, err_smp, tx_done_flag_set;
  logic [4:0] t_end_h, tx_done_flag_h;
  logic wr_stat;

  function automatic scm_byte_t rev8(input scm_byte_t v);
    scm_byte_t r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  assign gsm = mode_r[`SCM_MODE_GSM];
  assign odd = mode_r[`SCM_MODE_ODD];
  assign ck_hi = ctrl_r[`SCM_CTRL_CK_HI];
  assign ck_lo = ctrl_r[`SCM_CTRL_CK_LO];
  assign tx_en = ctrl_r[`SCM_CTRL_TXON] & card_on_r;
  // Receiver is independent of the transmitter
  assign rx_en = ctrl_r[`SCM_CTRL_RXON] & card_on_r;
  assign wr_stat = wr_stb && (addr == `SCM_ADDR_STAT);

  // Data line input synchroniser
  scm_sync #(.RST_VAL(1'b1)) u_line_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in(data_in),
    .sync_out(line_s)
  );

  // Base tick: half card clock period, 372 card clocks per etu
  assign tick_lim = 15'((({7'h00, baud_r} + 15'd1)
    << {mode_r[`SCM_MODE_PRE_HI], mode_r[`SCM_MODE_PRE_LO], 1'b0}) - 15'd1);
  assign tick = (tick_cnt_r >= tick_lim);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 15'h0000;
      sck_tgl_r <= 1'b0;
    end else if (ce) begin
      tick_cnt_r <= tick ? 15'h0000 : 15'(tick_cnt_r + 15'd1);
      if (tick) begin
        sck_tgl_r <= ~sck_tgl_r;
      end
    end
  end

  // Clock pin selection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
    end else if (ce) begin
      sck_oe <= ck_lo | gsm;
      sck_out <= (gsm && !ck_lo) ? ck_hi : sck_tgl_r;
    end
  end

  // Software registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= `SCM_RST_MODE;
      baud_r <= `SCM_RST_BAUD;
      ctrl_r <= `SCM_RST_CTRL;
      tdr_r <= `SCM_RST_TXD;
      order_r <= `SCM_RST_ORDER;
      inv_r <= `SCM_RST_INV;
      card_on_r <= `SCM_RST_ON;
    end else if (ce && wr_stb) begin
      unique case (addr)
        `SCM_ADDR_MODE: mode_r <= wr_data;
        `SCM_ADDR_BAUD: baud_r <= wr_data;
        `SCM_ADDR_CTRL: ctrl_r <= wr_data;
        `SCM_ADDR_TXD: tdr_r <= wr_data;
        `SCM_ADDR_CARD: begin
          order_r <= wr_data[`SCM_CARD_ORDER];
          inv_r <= wr_data[`SCM_CARD_INV];
          card_on_r <= wr_data[`SCM_CARD_ON];
        end
        default: ;
      endcase
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (ce && rd_stb) begin
      unique case (addr)
        `SCM_ADDR_MODE: rd_data <= mode_r;
        `SCM_ADDR_BAUD: rd_data <= baud_r;
        `SCM_ADDR_CTRL: rd_data <= ctrl_r;
        `SCM_ADDR_TXD: rd_data <= tdr_r;
        `SCM_ADDR_STAT: rd_data <= {txe_r, rxf_r, ovr_r, ers_r, per_r,
          tx_done_flag_r, 2'b00};
        `SCM_ADDR_RXD: rd_data <= rdr_r;
        `SCM_ADDR_CARD: rd_data <= `SCM_CARD_ONES
          | {4'h0, order_r, inv_r, 1'b0, card_on_r};
        default: rd_data <= 8'h00;
      endcase
    end
  end

  // Transmit character shaping
  assign d_tx = (order_r ? rev8(tdr_r) : tdr_r) ^ {8{inv_r}};
  assign tx_load = (t_state_r == SCM_TX_IDLE) && tx_en && !txe_r;
  assign t_hp = tick && (t_sub_r == 9'(`SCM_TICKS_HALF - 1));
  assign tx_done_flag_h = gsm ? 5'(`SCM_TX_DONE_FLAG_GSM_H) : 5'(`SCM_TX_DONE_FLAG_NORM_H);
  // Frame ends after the guard, or later when a resend is due
  assign t_end_h = err_seen_r ? 5'(`SCM_RETRY_H)
    : (gsm ? 5'(`SCM_GUARD_END_H) : 5'(`SCM_TX_DONE_FLAG_NORM_H));
  assign err_smp = (t_state_r == SCM_TX_FRAME) && t_hp
    && (t_half_r == 5'(`SCM_ERR_SMP_H - 1)) && !line_s;
  assign tx_done_flag_set = (!ctrl_r[`SCM_CTRL_TXON] && !ers_r)
    || ((t_state_r == SCM_TX_FRAME) && t_hp && !err_seen_r && txe_r
    && !err_smp && (t_half_r == tx_done_flag_h - 5'd1));

  // Transmitter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      t_state_r <= SCM_TX_IDLE;
      t_sub_r <= 9'h000;
      t_half_r <= 5'h00;
      frame_r <= 10'h3FF;
      err_seen_r <= 1'b0;
    end else if (ce) begin
      unique case (t_state_r)
        SCM_TX_IDLE: begin
          if (tx_load) begin
            t_state_r <= SCM_TX_FRAME;
            t_sub_r <= 9'h000;
            t_half_r <= 5'h00;
            err_seen_r <= 1'b0;
            frame_r <= {(^d_tx) ^ odd, d_tx, 1'b0};
          end
        end
        SCM_TX_FRAME: begin
          if (!tx_en) begin
            t_state_r <= SCM_TX_IDLE;
          end else if (tick) begin
            t_sub_r <= t_hp ? 9'h000 : 9'(t_sub_r + 9'd1);
            if (t_hp) begin
              t_half_r <= 5'(t_half_r + 5'd1);
              if (t_half_r == 5'(`SCM_ERR_SMP_H - 1)) begin
                err_seen_r <= !line_s;
              end
              if (t_half_r == t_end_h - 5'd1) begin
                if (err_seen_r) begin
                  t_half_r <= 5'h00; // Resend same frame
                  err_seen_r <= 1'b0;
                end else begin
                  t_state_r <= SCM_TX_IDLE;
                end
              end
            end
          end
        end
      endcase
    end
  end

  // Transmit flags: hardware set wins over software clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txe_r <= 1'b1;
      tx_done_flag_r <= 1'b1;
      ers_r <= 1'b0;
    end else if (ce) begin
      if (tx_load) begin
        txe_r <= 1'b1;
      end else if (wr_stat && !wr_data[`SCM_STAT_TXE]) begin
        txe_r <= 1'b0;
      end
      if (tx_done_flag_set) begin
        tx_done_flag_r <= 1'b1;
      end else if (wr_stat && !wr_data[`SCM_STAT_TXE] && txe_r) begin
        tx_done_flag_r <= 1'b0;
      end
      if (err_smp) begin
        ers_r <= 1'b1;
      end else if (wr_stat && !wr_data[`SCM_STAT_ERS]) begin
        ers_r <= 1'b0;
      end
    end
  end

  // Receive character assembly
  assign r_hp = tick && (r_sub_r == 9'(`SCM_TICKS_HALF - 1));
  assign rx_full = {line_s, rx_bits_r[8:1]};
  assign rx_done = (r_state_r == SCM_RX_FRAME) && r_hp
    && (r_half_r == 5'(`SCM_PAR_SMP_H));
  assign rx_perr = (^rx_full) != odd;
  assign rx_byte = (order_r ? rev8(rx_full[7:0]) : rx_full[7:0])
    ^ {8{inv_r}};

  // Receiver, started only by a falling start edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_state_r <= SCM_RX_IDLE;
      r_sub_r <= 9'h000;
      r_half_r <= 5'h00;
      rx_bits_r <= 9'h000;
      r_perr_r <= 1'b0;
      r_drv_r <= 1'b0;
      line_prev_r <= 1'b1;
    end else if (ce) begin
      line_prev_r <= line_s;
      unique case (r_state_r)
        SCM_RX_IDLE: begin
          r_drv_r <= 1'b0;
          if (rx_en && line_prev_r && !line_s) begin
            r_state_r <= SCM_RX_FRAME;
            r_sub_r <= 9'h000;
            r_half_r <= 5'h00;
            r_perr_r <= 1'b0;
          end
        end
        SCM_RX_FRAME: begin
          if (!rx_en) begin
            r_state_r <= SCM_RX_IDLE;
            r_drv_r <= 1'b0;
          end else if (tick) begin
            r_sub_r <= r_hp ? 9'h000 : 9'(r_sub_r + 9'd1);
            if (r_hp) begin
              r_half_r <= 5'(r_half_r + 5'd1);
              // Mid-bit sampling of data and parity bits
              if (!r_half_r[0] && r_half_r != 5'h00
                  && r_half_r <= 5'(`SCM_PAR_SMP_H)) begin
                rx_bits_r <= rx_full;
              end
              if (rx_done) begin
                r_perr_r <= rx_perr;
              end
              if (r_half_r == 5'(`SCM_ERR_ON_H - 1) && r_perr_r) begin
                r_drv_r <= 1'b1;
              end
              if (r_half_r == 5'(`SCM_ERR_OFF_H - 1)) begin
                r_drv_r <= 1'b0;
              end
              if (r_half_r == 5'(`SCM_RX_END_H - 1)) begin
                r_state_r <= SCM_RX_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // Receive data and flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdr_r <= `SCM_RST_RXD;
      rxf_r <= 1'b0;
      ovr_r <= 1'b0;
      per_r <= 1'b0;
    end else if (ce) begin
      if (rx_done && !rx_perr && !rxf_r) begin
        rdr_r <= rx_byte;
      end
      if (rx_done && !rx_perr && !rxf_r) begin
        rxf_r <= 1'b1;
      end else if (wr_stat && !wr_data[`SCM_STAT_RXF]) begin
        rxf_r <= 1'b0;
      end
      if (rx_done && !rx_perr && rxf_r) begin
        ovr_r <= 1'b1;
      end else if (wr_stat && !wr_data[`SCM_STAT_OVR]) begin
        ovr_r <= 1'b0;
      end
      if (rx_done && rx_perr) begin
        per_r <= 1'b1;
      end else if (wr_stat && !wr_data[`SCM_STAT_PAR]) begin
        per_r <= 1'b0;
      end
    end
  end

  // Open-drain data line: only ever pulled low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 1'b0;
      data_oe <= 1'b0;
    end else if (ce) begin
      data_out <= 1'b0;
      data_oe <= ((t_state_r == SCM_TX_FRAME)
        && (t_half_r < 5'(`SCM_FRAME_H))
        && !frame_r[t_half_r[4:1]])
        || r_drv_r;
    end
  end
endmodule

// File: scm_checker.sv
`timescale 1ns/1ps
`include "scm_map.svh"
module scm_checker #(
  parameter int ETU = 744
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire scm_pkg::scm_addr_t addr,
  input wire scm_pkg::scm_byte_t wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire scm_pkg::scm_byte_t rd_data,
  input wire logic data_in,
  input wire logic data_out,
  input wire logic data_oe,
  input wire logic sck_out,
  input wire logic sck_oe
);
  import scm_pkg::*;
  logic [31:0] run_r;
  logic [9:0] age_r;
  scm_byte_t mode_r, ctrl_r, baud_r;
  wire logic cfg_wr = wr_stb && ce && (addr == `SCM_ADDR_MODE ||
    addr == `SCM_ADDR_CTRL || addr == `SCM_ADDR_BAUD);
  // Length of the current low drive on the data line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) run_r <= '0;
    else run_r <= data_oe ? run_r + 32'h1 : '0;
  end
  // Shadow of the clock settings and cycles since they last changed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= `SCM_RST_MODE;
      ctrl_r <= `SCM_RST_CTRL;
      baud_r <= `SCM_RST_BAUD;
      age_r <= '0;
    end else if (cfg_wr) begin
      age_r <= '0;
      if (addr == `SCM_ADDR_MODE) mode_r <= wr_data;
      if (addr == `SCM_ADDR_CTRL) ctrl_r <= wr_data;
      if (addr == `SCM_ADDR_BAUD) baud_r <= wr_data;
    end else if (age_r != 10'h3FF) begin
      age_r <= age_r + 10'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_out_low: assert property (!data_out)
    else $error("data_out driven high");
  a_pulse_etu: assert property ($fell(data_oe) |-> run_r % ETU == 0)
    else $error("low drive not whole etu");
  a_run_max: assert property (run_r <= 10 * ETU)
    else $error("data line held low too long");
  a_clk_fixed: assert property (age_r >= 2 && mode_r[7] && !ctrl_r[0]
    |-> sck_oe && sck_out == ctrl_r[1]) else $error("clock pin not fixed");
  a_port_mode: assert property (age_r >= 2 && !mode_r[7] && !ctrl_r[0]
    |-> !sck_oe) else $error("clock pin driven in port mode");
  a_clk_toggle: assert property (age_r == 10'h3FF && ctrl_r[0]
    && baud_r == 8'h00 && mode_r[1:0] == 2'b00
    |-> sck_oe && sck_out != $past(sck_out)) else $error("card clock idle");
  a_status_pad: assert property (rd_stb && addr == `SCM_ADDR_STAT
    |=> rd_data[1:0] == 2'b00) else $error("status pad bits set");
  a_card_ones: assert property (rd_stb && addr == `SCM_ADDR_CARD
    |=> (rd_data & `SCM_CARD_ONES) == `SCM_CARD_ONES)
    else $error("card reg fixed ones lost");
  a_unmapped_zero: assert property (rd_stb && (addr < `SCM_ADDR_MODE ||
    addr > `SCM_ADDR_CARD) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!rd_stb |=> $stable(rd_data))
    else $error("read data moved without read");
endmodule
bind scm_top scm_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
  .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rd_data(rd_data), .data_in(data_in), .data_out(data_out),
  .data_oe(data_oe), .sck_out(sck_out), .sck_oe(sck_oe));

// File: scm_card.sv
`timescale 1ns/1ps
module scm_card #(
  parameter int ETU = 744
) (
  input wire logic ref_clk,
  input wire logic line,
  output logic card_low
);
  initial card_low = 1'b0;
  // Take a frame, optionally answer with an error pulse
  task automatic recv(input logic nack, output logic [8:0] bits);
    do @(negedge ref_clk); while (line !== 1'b0);
    repeat (ETU * 3 / 2) @(negedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      bits[i] = line;
      if (i < 8) repeat (ETU) @(negedge ref_clk);
    end
    if (nack) begin
      repeat (ETU) @(posedge ref_clk);
      card_low <= 1'b1;
      repeat (ETU) @(posedge ref_clk);
      card_low <= 1'b0;
    end
  endtask
  // Send a frame, then look for the error pulse
  task automatic send(input logic [8:0] bits, output logic err);
    @(posedge ref_clk);
    card_low <= 1'b1;
    repeat (ETU) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      card_low <= ~bits[i];
      repeat (ETU) @(posedge ref_clk);
    end
    card_low <= 1'b0;
    repeat (ETU * 8 / 10) @(negedge ref_clk);
    err = ~line;
    repeat (ETU * 3) @(posedge ref_clk);
  endtask
endmodule

// File: smart_card_serial_mode_test.sv
`timescale 1ns/1ps
`include "scm_map.svh"
module smart_card_serial_mode_test;
  import scm_pkg::*;
  localparam int ETU = 744;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  scm_addr_t addr = '0;
  scm_byte_t wr_data = '0;
  scm_byte_t rd_data, v;
  logic data_out, data_oe, sck_out, sck_oe, card_low, err;
  wire logic line = ~data_oe & ~card_low;
  logic [8:0] b1, b2;
  int fail_count = 0;
  int n_tests = 0;
  scm_byte_t rv[8] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h84, 8'h00, 8'hF2, 8'h00};
  scm_byte_t cm[4] = '{8'h28, 8'hA8, 8'hA8, 8'h28};
  scm_byte_t cc[4] = '{8'h00, 8'h00, 8'h02, 8'h01};
  logic co[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  always #12.5 ref_clk = ~ref_clk;
  scm_top u_scm_top (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .data_in(line), .data_out(data_out), .data_oe(data_oe),
    .sck_out(sck_out), .sck_oe(sck_oe));
  scm_card #(.ETU(ETU)) u_scm_card (.ref_clk(ref_clk), .line(line),
    .card_low(card_low));
  task automatic wr(input scm_addr_t a, input scm_byte_t d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input scm_addr_t a, output scm_byte_t d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    d = rd_data;
  endtask
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input scm_addr_t a, input scm_byte_t e, input string n);
    scm_byte_t d;
    rd(a, d);
    chk(n, d, e);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Line image of a character: data in sent order, parity last
  function automatic logic [8:0] fbits(scm_byte_t d, logic msb, logic inv,
    logic odd);
    scm_byte_t b;
    b = inv ? ~d : d;
    if (msb) b = {<<{b}};
    return {(^b) ^ odd, b};
  endfunction
  initial begin
    repeat (95000) @(posedge ref_clk);
    fail_count++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rchk(`SCM_ADDR_MODE + 20'(i), rv[i], "reset");
    wr(`SCM_ADDR_MODE, 8'h28);
    wr(`SCM_ADDR_BAUD, 8'h00);
    wr(`SCM_ADDR_CARD, 8'h01);
    wr(`SCM_ADDR_CTRL, 8'h21);
    rchk(`SCM_ADDR_CARD, 8'hF3, "card");
    wr(`SCM_ADDR_TXD, 8'hA5);
    wr(`SCM_ADDR_STAT, 8'h7F);
    u_scm_card.recv(1'b0, b1);
    chk("tx_frame", b1, fbits(8'hA5, 0, 0, 0));
    repeat (ETU * 23 / 10) @(posedge ref_clk);
    rchk(`SCM_ADDR_STAT, 8'h80, "tx_done_flag_early");
    repeat (ETU) @(posedge ref_clk);
    rchk(`SCM_ADDR_STAT, 8'h84, "tx_done_flag");
    // Error pulse from the card forces a resend
    wr(`SCM_ADDR_TXD, 8'h3C);
    wr(`SCM_ADDR_STAT, 8'h7F);
    u_scm_card.recv(1'b1, b1);
    u_scm_card.recv(1'b0, b2);
    chk("resend", b2, fbits(8'h3C, 0, 0, 0));
    repeat (ETU * 3) @(posedge ref_clk);
    rd(`SCM_ADDR_STAT, v);
    chk("ers", v & 8'h10, 8'h10);
    wr(`SCM_ADDR_STAT, 8'hEF);
    rd(`SCM_ADDR_STAT, v);
    chk("ers_clr", v & 8'h10, 8'h00);
    // Inverse convention with the early done point
    wr(`SCM_ADDR_MODE, 8'hB8);
    wr(`SCM_ADDR_CARD, 8'h0D);
    wr(`SCM_ADDR_TXD, 8'h6E);
    wr(`SCM_ADDR_STAT, 8'h7F);
    u_scm_card.recv(1'b0, b1);
    chk("inv_frame", b1, fbits(8'h6E, 1, 1, 1));
    repeat (ETU * 13 / 10) @(posedge ref_clk);
    rchk(`SCM_ADDR_STAT, 8'h80, "gsm_early");
    repeat (ETU / 2) @(posedge ref_clk);
    rchk(`SCM_ADDR_STAT, 8'h84, "gsm_tx_done_flag");
    // Clock pin modes
    for (int i = 0; i < 4; i++) begin
      wr(`SCM_ADDR_CTRL, cc[i]);
      wr(`SCM_ADDR_MODE, cm[i]);
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      v[0] = sck_out;
      chk("sck_oe", sck_oe, co[i]);
      @(negedge ref_clk);
      if (i == 3) chk("sck_run", v[0] ^ sck_out, 1);
      else if (i > 0) chk("sck_level", sck_out, cc[i][1]);
    end
    // Reception: good, bad parity, then overrun
    wr(`SCM_ADDR_CARD, 8'h01);
    wr(`SCM_ADDR_CTRL, 8'h11);
    u_scm_card.send(fbits(8'h5A, 0, 0, 0), err);
    chk("rx_err", err, 0);
    rd(`SCM_ADDR_STAT, v);
    chk("rx_full", v & 8'h68, 8'h40);
    rchk(`SCM_ADDR_RXD, 8'h5A, "rx_data");
    b1 = fbits(8'h96, 0, 0, 0);
    b1[8] = ~b1[8];
    u_scm_card.send(b1, err);
    chk("nack", err, 1);
    u_scm_card.send(fbits(8'h11, 0, 0, 0), err);
    rd(`SCM_ADDR_STAT, v);
    chk("rx_flags", v & 8'h68, 8'h68);
    rchk(`SCM_ADDR_RXD, 8'h5A, "rx_keep");
    // Loop-back with no card traffic
    wr(`SCM_ADDR_STAT, 8'h87);
    wr(`SCM_ADDR_MODE, 8'hB8);
    wr(`SCM_ADDR_CARD, 8'h0D);
    wr(`SCM_ADDR_CTRL, 8'h31);
    wr(`SCM_ADDR_TXD, 8'hC3);
    wr(`SCM_ADDR_STAT, 8'h7F);
    repeat (ETU * 14) @(posedge ref_clk);
    rchk(`SCM_ADDR_RXD, 8'hC3, "loop");
    test_done();
  end
endmodule
